// ===== pkg/madc_pkg.sv
// Shared constants, types and helpers for the meter converter mode control block.
package madc_pkg;

  // APB geometry; register byte address is four times the register index.
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam logic [7:0] IDX_BOOST = 8'he0;
  localparam logic [7:0] IDX_CTRL = 8'he2;
  localparam logic [7:0] IDX_FUNC = 8'he4;
  localparam logic [7:0] IDX_RANGE = 8'he5;
  localparam logic [7:0] IDX_STATUS = 8'he6;
  localparam logic [7:0] IDX_RESULT = 8'he7;

  // Field positions in the converter control register.
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_SPD_BIT = 1;
  localparam int unsigned CTL_CUR_BIT = 2;
  localparam int unsigned CTL_RSV_BIT = 3;

  // Values after reset and after sleep entry.
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [2:0] FUNC_RESET = 3'h0;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic BOOST_RESET = 1'b0;
  localparam logic POL_RESET = 1'b1;

  // Measurement function codes.
  localparam logic [2:0] FN_DCV = 3'h0;
  localparam logic [2:0] FN_ACV = 3'h1;
  localparam logic [2:0] FN_DCA = 3'h2;
  localparam logic [2:0] FN_ACA = 3'h3;
  localparam logic [2:0] FN_RES = 3'h4;
  localparam logic [2:0] FN_CONTINUITY_MODE = 3'h5;
  localparam logic [2:0] FN_NONE = 3'h6;
  localparam logic [2:0] FN_ADAPTER_MODE = 3'h7;
  // Range code used by the unassigned function code.
  localparam logic [2:0] RANGE_NONE_FIXED = 3'h1;

  // Converter clock: oscillator divided by three.
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned OSC_DIV = 3;
  localparam int unsigned CONV_HZ = OSC_HZ / OSC_DIV;

  // Phase lengths in converter clocks; conversion periods in milliseconds and in converter clocks.
  localparam int unsigned CNT_W = 14;
  localparam int unsigned INPUT_CLKS = 2185;
  localparam int unsigned SLOW_MAX_COUNT = 4370;
  localparam int unsigned FAST_MAX_COUNT = 441;
  localparam int unsigned AZ_CLKS_DEFAULT = 400;
  localparam int unsigned SLOW_CONV_MS = 400;
  localparam int unsigned FAST_CONV_MS = 100;
  localparam int unsigned SLOW_CONV_CLKS = SLOW_CONV_MS * CONV_HZ / 1000;
  localparam int unsigned FAST_CONV_CLKS = FAST_CONV_MS * CONV_HZ / 1000;

  // Conversion phases.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_AUTOZERO,
    PH_INPUT,
    PH_REVERSE,
    PH_WAIT
  } madc_phase_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } madc_apb_req_t;

  // Stored converter settings.
  typedef struct packed {
    logic rsv;
    logic cur_high;
    logic fast;
    logic en;
    logic [2:0] func;
    logic [2:0] range;
  } madc_cfg_t;

  // Switch controls toward the analog front end.
  typedef struct packed {
    logic amp_on;
    logic comp_on;
    logic in_voltage;
    logic in_high_current;
    logic in_low_current;
    logic in_resistance;
    logic res_pin_a;
    logic res_pin_b;
    logic res_pin_c;
    logic booster_en;
    logic buzzer;
    logic [2:0] eff_range;
    logic [1:0] continuity_mode_thresh;
  } madc_ana_t;

  // True for the two modes that judge polarity.
  function automatic logic is_dc(input logic [2:0] f);
    is_dc = (f == FN_DCV) || (f == FN_DCA);
  endfunction : is_dc

  // True for the modes that measure resistance.
  function automatic logic is_res(input logic [2:0] f);
    is_res = (f == FN_RES) || (f == FN_CONTINUITY_MODE);
  endfunction : is_res

  // True for the current modes.
  function automatic logic is_cur(input logic [2:0] f);
    is_cur = (f == FN_DCA) || (f == FN_ACA);
  endfunction : is_cur

  // Range configuration actually applied for a function and range code.
  function automatic logic [2:0] eff_range(input logic [2:0] f, input logic [2:0] r);
    if (is_cur(f) || (f == FN_ADAPTER_MODE)) begin
      eff_range = 3'h0;
    end else if (f == FN_NONE) begin
      eff_range = RANGE_NONE_FIXED;
    end else if (f == FN_CONTINUITY_MODE) begin
      eff_range = {2'h0, r[1]};
    end else begin
      eff_range = r;
    end
  endfunction : eff_range

endpackage : madc_pkg

// ===== hdl/madc_clk_div3.sv
// Divider that turns oscillator rising edges into converter clock enable pulses.
`timescale 1ns/10ps
module madc_clk_div3 #(
  parameter int unsigned DIV = madc_pkg::OSC_DIV
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Oscillator level and divided enable.
  input wire logic i_osc_input,
  output logic o_tick
);
  import madc_pkg::*;

  if (DIV < 2 || DIV > 255) begin : g_bad_div
    $error("Divider ratio must be between 2 and 255.");
  end

  logic osc_q;
  logic [7:0] div_q;
  logic osc_rise;

  // The oscillator is already synchronous, so one stage finds its edges.
  assign osc_rise = i_osc_input & ~osc_q;

  // Count three oscillator edges per converter clock.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      osc_q <= 1'b0;
      div_q <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      osc_q <= i_osc_input;
      o_tick <= 1'b0;
      if (osc_rise) begin
        if (div_q == 8'(DIV - 1)) begin
          div_q <= 8'h00;
          o_tick <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end
    end
  end

  property p_tick_ratio;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_tick |-> $past(osc_rise) && ($past(div_q) == 8'(DIV - 1));
  endproperty
  a_tick_ratio: assert property (p_tick_ratio) else $error("Tick not on third edge.");

endmodule : madc_clk_div3

// ===== hdl/madc_mode_ctrl.sv
// Mode, range and phase control for the dual-slope converter behind an APB port.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module madc_mode_ctrl #(
  parameter int unsigned P_SLOW_CONV_CLKS = madc_pkg::SLOW_CONV_CLKS,
  parameter int unsigned P_AZ_CLKS = madc_pkg::AZ_CLKS_DEFAULT
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // APB slave.
  input madc_pkg::madc_apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Oscillator and power state.
  input wire logic i_osc_input,
  input wire logic i_sleep,
  // Analog judgements.
  input wire logic i_zero_cross,
  input wire logic i_polarity_neg,
  input wire logic i_continuity_mode_judge,
  // Front end controls and phase.
  output madc_pkg::madc_ana_t o_ana,
  output madc_pkg::madc_phase_t o_phase,
  output logic o_conv_event
);
  import madc_pkg::*;

  if (P_SLOW_CONV_CLKS < 2 || P_SLOW_CONV_CLKS >= (1 << CNT_W)) begin : g_bad_period
    $error("Slow conversion period does not fit the cycle counter.");
  end
  if (P_AZ_CLKS < 1 || P_AZ_CLKS >= (1 << CNT_W)) begin : g_bad_az
    $error("Auto-zero length does not fit the phase counter.");
  end

  madc_cfg_t cfg_q;
  logic boost_q;
  logic pol_q;
  logic [CNT_W-1:0] result_q;
  madc_phase_t phase_q;
  logic [CNT_W-1:0] ph_cnt_q;
  logic [CNT_W-1:0] cyc_q;
  logic tick;
  logic setup;
  logic acc_wr;
  logic [7:0] idx;
  logic mapped;
  logic cfg_wr;
  logic restart;
  logic restart_en;
  logic rev_done;
  logic polarity_flag;
  logic [CNT_W-1:0] max_count;
  logic [CNT_W-1:0] period;
  logic [31:0] rd_word;

  // Converter clock enable from the oscillator.
  madc_clk_div3 #(
    .DIV(OSC_DIV)
  ) u_div (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_osc_input(i_osc_input),
    .o_tick(tick)
  );

  // Bus decode; an access is always answered one cycle after setup.
  assign setup = i_apb.psel & ~i_apb.penable;
  assign acc_wr = i_apb.psel & i_apb.penable & o_pready & i_apb.pwrite & ~o_pslverr;
  assign idx = i_apb.paddr[9:2];
  assign mapped = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[11:10] == 2'h0) &&
                  ((idx == IDX_BOOST) || (idx == IDX_CTRL) || (idx == IDX_FUNC) ||
                   (idx == IDX_RANGE) || (idx == IDX_STATUS) || (idx == IDX_RESULT));

  // Writes are dropped while asleep because the registers are held clear then.
  assign cfg_wr = acc_wr & ~i_sleep &
                  ((idx == IDX_CTRL) || (idx == IDX_FUNC) || (idx == IDX_RANGE));
  assign restart = cfg_wr | i_sleep;
  // Enable that the conversion sees after this cycle's write.
  assign restart_en = ~i_sleep &
                      ((idx == IDX_CTRL) ? i_apb.pwdata[CTL_EN_BIT] : cfg_q.en);

  // Phase limits follow the speed bit.
  assign max_count = cfg_q.fast ? CNT_W'(FAST_MAX_COUNT) : CNT_W'(SLOW_MAX_COUNT);
  assign period = cfg_q.fast ? CNT_W'(FAST_CONV_CLKS) : CNT_W'(P_SLOW_CONV_CLKS);
  assign rev_done = tick && (phase_q == PH_REVERSE) &&
                    (i_zero_cross || (ph_cnt_q == max_count - CNT_W'(1)));

  // Polarity is only meaningful in the DC modes; adapter mode never judges it.
  assign polarity_flag = is_dc(cfg_q.func) ? pol_q : 1'b1;

  // Read mux; unused upper bits of every register read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (idx)
      IDX_BOOST: rd_word[0] = boost_q;
      IDX_CTRL: rd_word[3:0] = {cfg_q.rsv, cfg_q.cur_high, cfg_q.fast, cfg_q.en};
      IDX_FUNC: rd_word[2:0] = cfg_q.func;
      IDX_RANGE: rd_word[2:0] = cfg_q.range;
      IDX_STATUS: rd_word[4:0] = {i_continuity_mode_judge, polarity_flag, 3'(phase_q)};
      IDX_RESULT: rd_word[CNT_W-1:0] = result_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answer: ready rises in the cycle after setup, error flags unmapped words.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_pslverr <= ~mapped;
        o_prdata <= mapped ? rd_word : 32'h0000_0000;
      end else if (!i_apb.psel) begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // Settings registers; sleep holds them at their reset values.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cfg_q <= {CTRL_RESET, FUNC_RESET, RANGE_RESET};
      boost_q <= BOOST_RESET;
    end else if (i_sleep) begin
      cfg_q <= {CTRL_RESET, FUNC_RESET, RANGE_RESET};
      boost_q <= BOOST_RESET;
    end else if (acc_wr) begin
      unique case (idx)
        IDX_BOOST: boost_q <= i_apb.pwdata[0];
        IDX_CTRL: begin
          // The reserved bit is stored as written; nothing but the read mux uses it.
          cfg_q.rsv <= i_apb.pwdata[CTL_RSV_BIT];
          cfg_q.cur_high <= i_apb.pwdata[CTL_CUR_BIT];
          cfg_q.fast <= i_apb.pwdata[CTL_SPD_BIT];
          cfg_q.en <= i_apb.pwdata[CTL_EN_BIT];
        end
        IDX_FUNC: cfg_q.func <= i_apb.pwdata[2:0];
        IDX_RANGE: cfg_q.range <= i_apb.pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Phase sequencer; a settings write with enable set restarts from auto-zero at once, one with enable clear goes idle.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      phase_q <= PH_IDLE;
      ph_cnt_q <= '0;
      cyc_q <= '0;
    end else if (restart) begin
      phase_q <= restart_en ? PH_AUTOZERO : PH_IDLE;
      ph_cnt_q <= '0;
      cyc_q <= '0;
    end else if (tick) begin
      if (cyc_q != {CNT_W{1'b1}}) begin
        cyc_q <= cyc_q + CNT_W'(1);
      end
      ph_cnt_q <= ph_cnt_q + CNT_W'(1);
      unique case (phase_q)
        PH_IDLE: ph_cnt_q <= '0;
        PH_AUTOZERO: begin
          if (ph_cnt_q == CNT_W'(P_AZ_CLKS - 1)) begin
            phase_q <= PH_INPUT;
            ph_cnt_q <= '0;
          end
        end
        PH_INPUT: begin
          if (ph_cnt_q == CNT_W'(INPUT_CLKS - 1)) begin
            phase_q <= PH_REVERSE;
            ph_cnt_q <= '0;
          end
        end
        PH_REVERSE: begin
          if (rev_done) begin
            phase_q <= PH_WAIT;
            ph_cnt_q <= '0;
          end
        end
        PH_WAIT: begin
          // The fast period is shorter than one input phase, so it restarts at once.
          if (cyc_q >= period - CNT_W'(1)) begin
            phase_q <= PH_AUTOZERO;
            ph_cnt_q <= '0;
            cyc_q <= '0;
          end
        end
      endcase
    end
  end

  // Result count and polarity caught when reverse integration ends.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || i_sleep) begin
      result_q <= '0;
      pol_q <= POL_RESET;
    end else if (rev_done && !restart) begin
      result_q <= ph_cnt_q;
      pol_q <= ~i_polarity_neg;
    end
  end

  // Event pulse on a finished conversion, or when a restart cuts a running one.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_conv_event <= 1'b0;
    end else begin
      o_conv_event <= (rev_done && !restart) || (restart && (phase_q != PH_IDLE));
    end
  end

  // Front end switch settings, registered so every output comes from a flop.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_ana <= '0;
      o_phase <= PH_IDLE;
    end else begin
      o_phase <= phase_q;
      o_ana.amp_on <= (cfg_q.func == FN_ACV) || (cfg_q.func == FN_ACA);
      o_ana.comp_on <= cfg_q.func == FN_CONTINUITY_MODE;
      o_ana.in_voltage <= !is_cur(cfg_q.func) && !is_res(cfg_q.func);
      o_ana.in_high_current <= is_cur(cfg_q.func) && cfg_q.cur_high;
      o_ana.in_low_current <= is_cur(cfg_q.func) && !cfg_q.cur_high;
      o_ana.in_resistance <= is_res(cfg_q.func);
      if (is_res(cfg_q.func)) begin
        o_ana.res_pin_a <= (phase_q == PH_INPUT) || (phase_q == PH_REVERSE);
        o_ana.res_pin_b <= phase_q == PH_REVERSE;
        o_ana.res_pin_c <= 1'b0;
      end else begin
        // Outside resistance the speed bit picks the integration resistor.
        o_ana.res_pin_a <= !cfg_q.fast && ((phase_q == PH_INPUT) || (phase_q == PH_REVERSE));
        o_ana.res_pin_b <= 1'b0;
        o_ana.res_pin_c <= cfg_q.fast && ((phase_q == PH_INPUT) || (phase_q == PH_REVERSE));
      end
      o_ana.booster_en <= boost_q;
      o_ana.buzzer <= (cfg_q.func == FN_CONTINUITY_MODE) && cfg_q.en && i_continuity_mode_judge;
      o_ana.eff_range <= eff_range(cfg_q.func, cfg_q.range);
      o_ana.continuity_mode_thresh <= (cfg_q.func == FN_CONTINUITY_MODE) ? cfg_q.range[1:0] : 2'h0;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_cfg_write;
    cfg_wr && restart_en;
  endsequence

  sequence s_input_end;
    (phase_q == PH_INPUT) ##1 (phase_q == PH_REVERSE);
  endsequence

  property p_write_restart;
    s_cfg_write |=> (phase_q == PH_AUTOZERO) && (ph_cnt_q == '0) && (cyc_q == '0);
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("No auto-zero restart.");

  property p_idle_off;
    !cfg_q.en |-> (phase_q == PH_IDLE);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("Conversion runs while off.");

  property p_input_len;
    s_input_end |-> ($past(ph_cnt_q) == CNT_W'(INPUT_CLKS - 1)) && $past(tick);
  endproperty
  a_input_len: assert property (p_input_len) else $error("Input phase length wrong.");

  property p_res_pins;
    is_res(cfg_q.func) && (phase_q == PH_REVERSE) |=> o_ana.res_pin_a && o_ana.res_pin_b;
  endproperty
  a_res_pins: assert property (p_res_pins) else $error("Reverse pins not parallel.");

  property p_res_input_pin;
    is_res(cfg_q.func) && (phase_q == PH_INPUT) |=> o_ana.res_pin_a && !o_ana.res_pin_b;
  endproperty
  a_res_input_pin: assert property (p_res_input_pin) else $error("Input pin wrong.");

  property p_buzzer;
    (cfg_q.func == FN_CONTINUITY_MODE) && cfg_q.en |=> (o_ana.buzzer == $past(i_continuity_mode_judge));
  endproperty
  a_buzzer: assert property (p_buzzer) else $error("Buzzer not following judgement.");

  property p_amp;
    (cfg_q.func == FN_DCV) || is_res(cfg_q.func) |=> !o_ana.amp_on ##1 1'b1;
  endproperty
  a_amp: assert property (p_amp) else $error("Amplifier on in a non-AC mode.");

  property p_polarity;
    setup && mapped && (idx == IDX_STATUS) && !is_dc(cfg_q.func) |=> o_prdata[3];
  endproperty
  a_polarity: assert property (p_polarity) else $error("Polarity not fixed positive.");

  property p_sleep_clear;
    i_sleep |=> (cfg_q == '0) && !boost_q && (phase_q == PH_IDLE);
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("Sleep did not clear.");

  property p_func_read;
    setup && (idx == IDX_FUNC || idx == IDX_RANGE) && mapped |=> (o_prdata[31:3] == '0);
  endproperty
  a_func_read: assert property (p_func_read) else $error("Upper bits read nonzero.");

  property p_cur_sel;
    is_cur(cfg_q.func) |=> (o_ana.in_high_current == $past(cfg_q.cur_high)) &&
                           (o_ana.in_low_current == !$past(cfg_q.cur_high));
  endproperty
  a_cur_sel: assert property (p_cur_sel) else $error("Current input wrong.");

  property p_continuity_mode_range;
    (cfg_q.func == FN_CONTINUITY_MODE) |=> (o_ana.eff_range == {2'h0, $past(cfg_q.range[1])});
  endproperty
  a_continuity_mode_range: assert property (p_continuity_mode_range) else $error("Continuity range wrong.");

endmodule : madc_mode_ctrl

// ===== sim/tb.sv
// Self-checking testbench for the meter converter mode control block.
`timescale 1ns/10ps
module tb;
  import madc_pkg::*;

  // Design inputs, all given a value at time zero.
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_osc_input = 1'b0;
  logic i_sleep = 1'b0;
  logic i_zero_cross = 1'b0;
  logic i_polarity_neg = 1'b1;
  logic i_continuity_mode_judge = 1'b0;
  madc_apb_req_t i_apb = '0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_conv_event;
  madc_ana_t o_ana;
  madc_phase_t o_phase;
  int error_cnt = 0;
  int n_checks = 0;
  int ev_cnt = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] regs [4] = '{IDX_BOOST, IDX_CTRL, IDX_FUNC, IDX_RANGE};

  // Short period and auto-zero counts; the input phase alone still takes 2185 converter clocks, over thirteen thousand cycles.
  madc_mode_ctrl #(.P_SLOW_CONV_CLKS(50), .P_AZ_CLKS(4)) u_dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_apb(i_apb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_osc_input(i_osc_input),
    .i_sleep(i_sleep), .i_zero_cross(i_zero_cross), .i_polarity_neg(i_polarity_neg),
    .i_continuity_mode_judge(i_continuity_mode_judge), .o_ana(o_ana), .o_phase(o_phase),
    .o_conv_event(o_conv_event)
  );

  // Clock, and an oscillator toggling each cycle so one converter tick spans six cycles.
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) i_osc_input <= ~i_osc_input;

  // The event is a one-cycle pulse, so it is counted here rather than polled.
  always @(posedge i_ref_clk) if (o_conv_event === 1'b1) ev_cnt++;

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // Compares one value against its expectation.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; pready, read data and error are all taken at the rising edge that
  // completes the access, and the request is released only after that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge i_ref_clk);
    i_apb.penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = o_prdata;
    er = o_pslverr;
    i_apb <= '0;
  endtask : apb

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, ad(i), d);
  endtask : wr

  task automatic rdx(input logic [7:0] i);
    apb(1'b0, ad(i), 32'h0);
  endtask : rdx

  // Waits at falling edges for a phase, counting the cycles spent.
  task automatic wait_ph(input madc_phase_t ph, input int bound, output int n);
    n = 0;
    while (o_phase !== ph) begin
      @(negedge i_ref_clk);
      n++;
      if (n > bound) begin
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask : wait_ph

  // Range configuration that each function and range code should apply.
  function automatic logic [2:0] exp_rng(input logic [2:0] f, input logic [2:0] r);
    if (f == 3'h2 || f == 3'h3 || f == 3'h7) return 3'h0;
    if (f == 3'h6) return RANGE_NONE_FIXED;
    if (f == 3'h5) return {2'h0, r[1]};
    return r;
  endfunction : exp_rng

  // Main sequence.
  initial begin
    int n;
    int bad;
    int m;
    logic [31:0] v;
    logic [2:0] r;
    logic [3:0] c;
    void'($urandom(18));
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdx(regs[i]);
      chk(rd, 32'h0);
    end
    rdx(IDX_STATUS);
    chk({27'h0, rd[4:0]}, 32'h8);
    $display("test reset done");
    // Random readback; the top bits of the function and range registers must read back as zero.
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(IDX_FUNC, v);
      rdx(IDX_FUNC);
      chk(rd, {29'h0, v[2:0]});
      wr(IDX_RANGE, v);
      rdx(IDX_RANGE);
      chk(rd, {29'h0, v[2:0]});
      wr(IDX_BOOST, v);
      rdx(IDX_BOOST);
      chk(rd[0], v[0]);
    end
    $display("test readback done");
    wr(IDX_BOOST, 32'h1);
    // Settling time for the boosted supply, scaled to the fast bench oscillator.
    repeat (2000) @(posedge i_ref_clk);
    for (int f = 0; f < 8; f++) begin
      v = $urandom;
      r = v[2:0];
      c = {1'b0, v[4:3], 1'b1};
      i_continuity_mode_judge <= v[5];
      wr(IDX_CTRL, {28'h0, c});
      wr(IDX_FUNC, f);
      wr(IDX_RANGE, {29'h0, r});
      repeat (3) @(posedge i_ref_clk);
      chk(o_ana.amp_on, f == 1 || f == 3);
      chk(o_ana.comp_on, f == 5);
      chk(o_ana.buzzer, f == 5 && v[5]);
      chk(o_ana.eff_range, exp_rng(f[2:0], r));
      chk({o_ana.in_high_current, o_ana.in_low_current},
          (f == 2 || f == 3) ? {c[2], ~c[2]} : 2'h0);
      chk(o_ana.booster_en, 1'b1);
      chk({o_ana.in_voltage, o_ana.in_resistance}, (f == 4 || f == 5) ? 2'h1 :
          (f == 2 || f == 3) ? 2'h0 : 2'h2);
      chk(o_ana.continuity_mode_thresh, (f == 5) ? r[1:0] : 2'h0);
      rdx(IDX_CTRL);
      chk(rd, {28'h0, c});
      rdx(IDX_STATUS);
      chk(rd[2:0], 3'h1);
      if (f != 0 && f != 2) chk(rd[3], 1'b1);
    end
    $display("test modes done");
    // Resistance conversion in fast mode with no zero crossing, so reverse runs to its maximum.
    i_zero_cross <= 1'b0;
    wr(IDX_FUNC, FN_RES);
    wr(IDX_CTRL, 32'h3);
    wait_ph(PH_INPUT, 300, n);
    repeat (3) @(negedge i_ref_clk);
    chk({o_ana.res_pin_a, o_ana.res_pin_b, o_ana.res_pin_c}, 3'h4);
    wait_ph(PH_REVERSE, 14000, n);
    chk(n + 3, INPUT_CLKS * 6);
    repeat (3) @(negedge i_ref_clk);
    chk({o_ana.res_pin_a, o_ana.res_pin_b, o_ana.res_pin_c}, 3'h6);
    m = ev_cnt;
    wait_ph(PH_WAIT, 3000, n);
    chk(n + 3, FAST_MAX_COUNT * 6);
    repeat (3) @(negedge i_ref_clk);
    chk(ev_cnt - m, 1);
    $display("test conversion done");
    // Slow DC conversion cut short by a zero crossing; the negative sign must be reported.
    wr(IDX_FUNC, FN_DCV);
    wr(IDX_CTRL, 32'h1);
    wait_ph(PH_REVERSE, 14000, n);
    repeat (60) @(posedge i_ref_clk);
    i_zero_cross <= 1'b1;
    wait_ph(PH_WAIT, 20, n);
    i_zero_cross <= 1'b0;
    rdx(IDX_STATUS);
    chk(rd[3], 1'b0);
    $display("test zero crossing done");
    // A range write in mid-conversion must restart from auto-zero.
    wait_ph(PH_INPUT, 300, n);
    m = ev_cnt;
    wr(IDX_RANGE, 32'h1);
    repeat (2) @(negedge i_ref_clk);
    chk(ev_cnt - m, 1);
    chk(o_phase, PH_AUTOZERO);
    // With enable clear no conversion may reach the input phase.
    wr(IDX_CTRL, 32'h0);
    bad = 0;
    repeat (400) begin
      @(negedge i_ref_clk);
      if (o_phase === PH_INPUT || o_phase === PH_REVERSE) bad++;
    end
    chk(bad, 0);
    $display("test restart done");
    // Sleep clears everything, and a write during sleep is ignored.
    wr(IDX_CTRL, 32'h1);
    m = ev_cnt;
    i_sleep <= 1'b1;
    wr(IDX_FUNC, 32'h3);
    i_sleep <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rdx(regs[i]);
      chk(rd[2:0], 3'h0);
    end
    chk(o_ana.booster_en, 1'b0);
    chk(ev_cnt - m, 1);
    $display("test sleep done");
    // An unmapped address is refused with an error and reads zero.
    apb(1'b0, 12'h3a0, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    tally_and_finish();
  end

endmodule : tb
